// ==== core/servo_stop_sequencer.sv ====
/*
  Servo stop sequencer: enable, stop on disable or alarm, state after the
  stop, holding brake, ready and fault outputs, Wishbone register file.
  Assumes classic Wishbone masters on sys_clk, pins asynchronous to sys_clk,
  motor_speed produced on sys_clk.
*/
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module servo_stop_sequencer
  import stop_seq_pkg::*;
#(
  parameter int unsigned INIT_CNT   = stop_seq_pkg::INIT_CYCLES,
  parameter int unsigned SETTLE_CNT = stop_seq_pkg::SETTLE_CYCLES,
  parameter int unsigned TICK_CNT   = stop_seq_pkg::TICK_CYCLES
)
(
  input  wire logic                     sys_clk,
  input  wire logic                     nrst,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [stop_seq_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output var  logic [31:0]              wb_dat_o,
  output var  logic                     wb_ack_o,
  input  wire logic                     servo_enable_input,
  input  wire logic                     fault_clear_input,
  input  wire logic                     alarm_input,
  input  wire logic                     main_power_input,
  input  wire logic [15:0]              motor_speed,
  output var  logic                     servo_on_status,
  output var  logic                     cmd_accept_output,
  output var  logic                     drive_ready_output,
  output var  logic                     fault_output,
  output var  logic                     motor_power_output,
  output var  logic                     reverse_torque_output,
  output var  logic [15:0]              torque_limit_output,
  output var  logic                     dyn_brake_output,
  output var  logic                     holding_brake_output,
  output var  logic                     brake_release_output_valid,
  output var  logic                     brake_engage_output
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [3:0]       pins_s;
  logic             enable_s;
  logic             clear_s;
  logic             alarm_s;
  logic             power_s;
  logic             clear_d_r;
  logic             clear_rise;
  logic             stop_done;
  logic             decel_start;

  logic [15:0]      dis_sel_r, dis_sel_nxt;
  logic [15:0]      flt_sel_r, flt_sel_nxt;
  logic [15:0]      torque_r, torque_nxt;
  logic [15:0]      max_time_r, max_time_nxt;
  logic [15:0]      thresh_r, thresh_nxt;
  logic [31:0]      rdata_nxt;
  logic             ack_nxt;

  seq_state_e       state_r, state_nxt;
  stop_method_e     method_r, method_nxt;
  after_stop_e      after_r, after_nxt;
  logic [15:0]      trq_lat_r, trq_lat_nxt;
  logic             fstop_r, fstop_nxt;
  logic             fault_r, fault_nxt;
  logic [CNT_W-1:0] init_r, init_nxt;
  logic [CNT_W-1:0] settle_r, settle_nxt;

  logic             on_nxt, acc_nxt, rdy_nxt, pwr_nxt, rev_nxt, dyn_nxt, rel_nxt;
  logic [15:0]      tlim_nxt;

  // ****************************************************************
  // pin synchronisers and deceleration timer
  // ****************************************************************
  sync2 #(.W(4)) u_sync
  (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .async_in ({main_power_input, alarm_input, fault_clear_input, servo_enable_input}),
    .sync_out (pins_s)
  );

  assign enable_s   = pins_s[0];
  assign clear_s    = pins_s[1];
  assign alarm_s    = pins_s[2];
  assign power_s    = pins_s[3];
  assign clear_rise = clear_s && !clear_d_r;

  stop_timer #(.TICK(TICK_CNT)) u_timer
  (
    .sys_clk              (sys_clk),
    .nrst                 (nrst),
    .start                (decel_start),
    .active               (state_r == S_DECEL),
    .max_stop_time        (max_time_r),
    .motor_speed          (motor_speed),
    .stop_speed_threshold (thresh_r),
    .done                 (stop_done)
  );

  // ****************************************************************
  // wishbone slave: one wait state, unmapped reads zero
  // ****************************************************************
  always_comb
  begin
    dis_sel_nxt  = dis_sel_r;
    flt_sel_nxt  = flt_sel_r;
    torque_nxt   = torque_r;
    max_time_nxt = max_time_r;
    thresh_nxt   = thresh_r;
    rdata_nxt    = 32'h0000_0000;
    ack_nxt      = wb_cyc_i && wb_stb_i && !wb_ack_o;
    if (ack_nxt && wb_we_i)
    begin
      unique case (wb_adr_i)
        ADR_DIS_SEL:   dis_sel_nxt  = merge(dis_sel_r, wb_dat_i, wb_sel_i) & SEL_MASK;
        ADR_FLT_SEL:   flt_sel_nxt  = merge(flt_sel_r, wb_dat_i, wb_sel_i) & SEL_MASK;
        ADR_TORQUE:    torque_nxt   = merge(torque_r, wb_dat_i, wb_sel_i);
        ADR_MAX_TIME:  max_time_nxt = merge(max_time_r, wb_dat_i, wb_sel_i);
        ADR_THRESHOLD: thresh_nxt   = merge(thresh_r, wb_dat_i, wb_sel_i);
        default:       ;
      endcase
    end
    else if (ack_nxt)
    begin
      unique case (wb_adr_i)
        ADR_DIS_SEL:   rdata_nxt = {16'h0000, dis_sel_r};
        ADR_FLT_SEL:   rdata_nxt = {16'h0000, flt_sel_r};
        ADR_TORQUE:    rdata_nxt = {16'h0000, torque_r};
        ADR_MAX_TIME:  rdata_nxt = {16'h0000, max_time_r};
        ADR_THRESHOLD: rdata_nxt = {16'h0000, thresh_r};
        ADR_STATUS:    rdata_nxt = {20'h0_0000, enable_s, power_s, cmd_accept_output,
                                    motor_power_output, dyn_brake_output,
                                    brake_release_output_valid, fault_output,
                                    drive_ready_output, servo_on_status, state_r};
        default:       rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] sel);
    merge[7:0]  = sel[0] ? d[7:0]  : old[7:0];
    merge[15:8] = sel[1] ? d[15:8] : old[15:8];
  endfunction

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dis_sel_r  <= DIS_SEL_RST;
      flt_sel_r  <= FLT_SEL_RST;
      torque_r   <= TORQUE_RST;
      max_time_r <= MAX_TIME_RST;
      thresh_r   <= THRESHOLD_RST;
      wb_dat_o   <= 32'h0000_0000;
      wb_ack_o   <= 1'b0;
    end
    else
    begin
      dis_sel_r  <= dis_sel_nxt;
      flt_sel_r  <= flt_sel_nxt;
      torque_r   <= torque_nxt;
      max_time_r <= max_time_nxt;
      thresh_r   <= thresh_nxt;
      wb_dat_o   <= rdata_nxt;
      wb_ack_o   <= ack_nxt;
    end
  end

  // ****************************************************************
  // stop sequence state machine
  // ****************************************************************
  always_comb
  begin
    state_nxt   = state_r;
    method_nxt  = method_r;
    after_nxt   = after_r;
    trq_lat_nxt = trq_lat_r;
    fstop_nxt   = fstop_r;
    fault_nxt   = fault_r;
    init_nxt    = init_r;
    settle_nxt  = '0;
    decel_start = 1'b0;
    unique case (state_r)
      S_INIT:
      begin
        if (init_r != CNT_W'(INIT_CNT - 1))
          init_nxt = init_r + CNT_W'(1);
        else if (power_s)
          state_nxt = alarm_s ? S_FAULT : S_READY;
      end
      S_READY:
      begin
        if (alarm_s)
          state_nxt = S_FAULT;
        else if (enable_s && power_s)
          state_nxt = S_RUN;
      end
      S_RUN:
      begin
        if (settle_r != CNT_W'(SETTLE_CNT - 1))
          settle_nxt = settle_r + CNT_W'(1);
        else
          settle_nxt = settle_r;
        if (alarm_s)
        begin
          state_nxt   = S_DECEL;
          decel_start = 1'b1;
          fstop_nxt   = 1'b1;
          method_nxt  = dec_method(flt_sel_r);
          after_nxt   = dec_after(flt_sel_r);
          trq_lat_nxt = torque_r;
        end
        else if (!enable_s || !power_s)
        begin
          state_nxt   = S_DECEL;
          decel_start = 1'b1;
          fstop_nxt   = 1'b0;
          method_nxt  = dec_method(dis_sel_r);
          after_nxt   = dec_after(dis_sel_r);
          trq_lat_nxt = torque_r;
        end
      end
      S_DECEL:
      begin
        if (alarm_s && !fstop_r)
        begin
          decel_start = 1'b1;
          fstop_nxt   = 1'b1;
          method_nxt  = dec_method(flt_sel_r);
          after_nxt   = dec_after(flt_sel_r);
        end
        else if (stop_done)
          state_nxt = fstop_r ? S_FAULT : S_STOPPED;
      end
      S_STOPPED:
      begin
        if (alarm_s)
          state_nxt = S_FAULT;
        else if (enable_s && power_s)
          state_nxt = S_RUN;
      end
      S_FAULT:
      begin
        if (clear_rise && !alarm_s)
          state_nxt = S_READY;
      end
      default:
        state_nxt = S_INIT;
    endcase
    // alarm set wins over a clear in the same cycle
    if (alarm_s)
      fault_nxt = 1'b1;
    else if (state_r == S_FAULT && clear_rise)
      fault_nxt = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r   <= S_INIT;
      method_r  <= M_DYNAMIC;
      after_r   <= A_HOLD;
      trq_lat_r <= 16'h0000;
      fstop_r   <= 1'b0;
      fault_r   <= 1'b0;
      init_r    <= '0;
      settle_r  <= '0;
      clear_d_r <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      method_r  <= method_nxt;
      after_r   <= after_nxt;
      trq_lat_r <= trq_lat_nxt;
      fstop_r   <= fstop_nxt;
      fault_r   <= fault_nxt;
      init_r    <= init_nxt;
      settle_r  <= settle_nxt;
      clear_d_r <= clear_s;
    end
  end

  // ****************************************************************
  // output decode from the next state, registered
  // ****************************************************************
  always_comb
  begin
    on_nxt   = (state_nxt == S_RUN);
    acc_nxt  = on_nxt && (settle_nxt == CNT_W'(SETTLE_CNT - 1));
    rdy_nxt  = power_s && !fault_nxt &&
               (state_nxt == S_READY || state_nxt == S_RUN ||
                state_nxt == S_STOPPED || state_nxt == S_DECEL);
    pwr_nxt  = on_nxt || (state_nxt == S_DECEL && method_nxt == M_REVERSE);
    rev_nxt  = (state_nxt == S_DECEL) && (method_nxt == M_REVERSE);
    tlim_nxt = rev_nxt ? trq_lat_nxt : 16'h0000;
    rel_nxt  = on_nxt || (state_nxt == S_DECEL);
    unique case (state_nxt)
      S_INIT, S_READY: dyn_nxt = 1'b1;
      S_RUN:           dyn_nxt = 1'b0;
      S_DECEL:         dyn_nxt = (method_nxt == M_DYNAMIC);
      S_STOPPED, S_FAULT:
        dyn_nxt = (after_nxt == A_DYNAMIC);
      default:         dyn_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      servo_on_status            <= 1'b0;
      cmd_accept_output          <= 1'b0;
      drive_ready_output         <= 1'b0;
      fault_output               <= 1'b0;
      motor_power_output         <= 1'b0;
      reverse_torque_output      <= 1'b0;
      torque_limit_output        <= 16'h0000;
      dyn_brake_output           <= 1'b1;
      holding_brake_output       <= 1'b0;
      brake_release_output_valid <= 1'b0;
      brake_engage_output        <= 1'b1;
    end
    else
    begin
      servo_on_status            <= on_nxt;
      cmd_accept_output          <= acc_nxt;
      drive_ready_output         <= rdy_nxt;
      fault_output               <= fault_nxt;
      motor_power_output         <= pwr_nxt;
      reverse_torque_output      <= rev_nxt;
      torque_limit_output        <= tlim_nxt;
      dyn_brake_output           <= dyn_nxt;
      holding_brake_output       <= rel_nxt;  // high releases the brake
      brake_release_output_valid <= rel_nxt;
      brake_engage_output        <= !rel_nxt; // invalid only while released
    end
  end

endmodule
`default_nettype wire

// ==== core/stop_seq_pkg.sv ====
/*
  Constants, field layouts, register map and state encodings of the servo
  stop sequencer.
  Assumes a 20 MHz system clock and a classic Wishbone register bus.
*/
package stop_seq_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned INIT_TIME_US   = 1000;   // processor start-up time
  localparam int unsigned SETTLE_TIME_US = 10000;  // servo-on to command accept
  localparam int unsigned TICK_TIME_US   = 1000;   // stop-time unit, 1 ms
  localparam int unsigned INIT_CYCLES    = (INIT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_CYCLES  = (SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TICK_CYCLES    = (TICK_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W          = 24;

  // ****************************************************************
  // register map, byte addresses
  // ****************************************************************
  localparam int unsigned ADR_W = 8;
  localparam logic [7:0] ADR_DIS_SEL   = 8'h00;
  localparam logic [7:0] ADR_FLT_SEL   = 8'h04;
  localparam logic [7:0] ADR_TORQUE    = 8'h08;
  localparam logic [7:0] ADR_MAX_TIME  = 8'h0c;
  localparam logic [7:0] ADR_THRESHOLD = 8'h10;
  localparam logic [7:0] ADR_STATUS    = 8'h14;

  // ****************************************************************
  // fields and reset values
  // ****************************************************************
  localparam int unsigned SEL_METHOD_LSB = 0;
  localparam int unsigned SEL_AFTER_LSB  = 4;
  localparam logic [15:0] SEL_MASK       = 16'h0033;
  localparam logic [15:0] DIS_SEL_RST    = 16'h0010;
  localparam logic [15:0] FLT_SEL_RST    = 16'h0012;
  localparam logic [15:0] TORQUE_RST     = 16'h0100;
  localparam logic [15:0] MAX_TIME_RST   = 16'h03e8;
  localparam logic [15:0] THRESHOLD_RST  = 16'h0032;

  // ****************************************************************
  // encodings
  // ****************************************************************
  typedef enum logic [1:0]
  {
    M_REVERSE = 2'b00,
    M_COAST   = 2'b01,
    M_DYNAMIC = 2'b10
  } stop_method_e;

  typedef enum logic [1:0]
  {
    A_FREE    = 2'b00,
    A_DYNAMIC = 2'b01,
    A_HOLD    = 2'b10
  } after_stop_e;

  typedef enum logic [2:0]
  {
    S_INIT    = 3'b000,
    S_READY   = 3'b001,
    S_RUN     = 3'b010,
    S_DECEL   = 3'b011,
    S_STOPPED = 3'b100,
    S_FAULT   = 3'b101
  } seq_state_e;

  // unused code 2'b11 of the stop-method field falls back to dynamic braking
  function automatic stop_method_e dec_method(input logic [15:0] sel);
    logic [1:0] f;
    f = sel[SEL_METHOD_LSB +: 2];
    dec_method = (f == 2'b11) ? M_DYNAMIC : stop_method_e'(f);
  endfunction

  // unused code 2'b11 of the after-stop field falls back to holding brake
  function automatic after_stop_e dec_after(input logic [15:0] sel);
    logic [1:0] f;
    f = sel[SEL_AFTER_LSB +: 2];
    dec_after = (f == 2'b11) ? A_HOLD : after_stop_e'(f);
  endfunction

endpackage

// ==== core/sync2.sv ====
/*
  Two flip-flop synchroniser for a group of independent level inputs.
  Assumes each bit is a slow level from a pin; no word coherence.
*/
`timescale 1ns/100ps
`default_nettype none
module sync2
#(
  parameter int unsigned W = 1
)
(
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  // ****************************************************************
  // two stages, first stage read only by the second
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_r   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule
`default_nettype wire

// ==== core/stop_timer.sv ====
/*
  Deceleration interval timer: counts milliseconds from a start pulse and
  flags the end when the time limit passes or the speed drops below the
  threshold, whichever is first.
  Assumes motor_speed is an unsigned magnitude on the system clock.
*/
`timescale 1ns/100ps
`default_nettype none
module stop_timer
  import stop_seq_pkg::*;
#(
  parameter int unsigned TICK = stop_seq_pkg::TICK_CYCLES
)
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        start,
  input  wire logic        active,
  input  wire logic [15:0] max_stop_time,
  input  wire logic [15:0] motor_speed,
  input  wire logic [15:0] stop_speed_threshold,
  output var  logic        done
);

  logic [CNT_W-1:0] pre_r;
  logic [CNT_W-1:0] pre_nxt;
  logic [15:0]      ms_r;
  logic [15:0]      ms_nxt;

  // ****************************************************************
  // millisecond prescaler and counter, restarted by start
  // ****************************************************************
  always_comb
  begin
    pre_nxt = pre_r;
    ms_nxt  = ms_r;
    if (start)
    begin
      pre_nxt = '0;
      ms_nxt  = '0;
    end
    else if (active)
    begin
      if (pre_r == CNT_W'(TICK - 1))
      begin
        pre_nxt = '0;
        if (ms_r != 16'hffff)
          ms_nxt = ms_r + 16'h0001;
      end
      else
        pre_nxt = pre_r + CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pre_r <= '0;
      ms_r  <= '0;
    end
    else
    begin
      pre_r <= pre_nxt;
      ms_r  <= ms_nxt;
    end
  end

  // end of interval: first of time limit or low speed
  assign done = active && !start &&
                ((motor_speed < stop_speed_threshold) || (ms_r >= max_stop_time));

endmodule
`default_nettype wire

// ==== dv/stop_seq_checker.sv ====
/*
  Checker of the stop sequencer: relations between its output pins and main_power_input.
  Assumes it is bound to the top module, one clock, reset nrst.
*/
`timescale 1ns/100ps
`default_nettype none
module stop_seq_checker
(
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic        main_power_input,
  input wire logic        servo_on_status,
  input wire logic        cmd_accept_output,
  input wire logic        drive_ready_output,
  input wire logic        fault_output,
  input wire logic        motor_power_output,
  input wire logic        reverse_torque_output,
  input wire logic [15:0] torque_limit_output,
  input wire logic        dyn_brake_output,
  input wire logic        holding_brake_output,
  input wire logic        brake_release_output_valid,
  input wire logic        brake_engage_output
);
  // ********
  // assertions
  // ********
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  chk_run_power:
  assert property (servo_on_status |-> motor_power_output && !dyn_brake_output)
    else $error("run without motor power");
  chk_brake_pair:
  assert property (brake_release_output_valid != brake_engage_output)
    else $error("brake outputs disagree");
  chk_brake_pin:
  assert property (brake_engage_output |-> !holding_brake_output)
    else $error("brake pin released while engaged");
  chk_rev_torque:
  assert property (reverse_torque_output |-> motor_power_output && !servo_on_status)
    else $error("reverse torque without power");
  chk_torque_idle:
  assert property (!reverse_torque_output |-> torque_limit_output == 16'h0000)
    else $error("torque limit outside braking");
  chk_fault_ready:
  assert property (fault_output |-> !drive_ready_output)
    else $error("ready during fault");
  chk_ready_power:
  assert property ($rose(drive_ready_output) |-> $past(main_power_input, 3))
    else $error("ready without main power");
  chk_accept_wait:
  assert property ($rose(cmd_accept_output) |-> $past(servo_on_status, 8))
    else $error("commands accepted too early");
  chk_stop_unpowered:
  assert property (brake_engage_output |-> !motor_power_output && !reverse_torque_output)
    else $error("brake engaged on powered motor");
endmodule
`default_nettype wire

// ==== dv/motor_model.sv ====
/*
  Motor and load: speed rises while driven and falls by braking kind.
  Assumes drive outputs change on sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module motor_model
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        motor_power_output,
  input  wire logic        reverse_torque_output,
  input  wire logic        dyn_brake_output,
  output var  logic [15:0] motor_speed
);
  logic [15:0] speed_nxt;
  logic [15:0] dec;
  // speed step from drive and braking state
  always_comb
  begin
    dec = 16'h0001;       // coasting drag only
    if (reverse_torque_output)
      dec = 16'h0014;     // opposing torque
    else if (dyn_brake_output)
      dec = 16'h000a;     // braking resistor
    if (motor_power_output && !reverse_torque_output)
      speed_nxt = (motor_speed < 16'h03e8) ? motor_speed + 16'h0032 : motor_speed;
    else
      speed_nxt = (motor_speed > dec) ? motor_speed - dec : 16'h0000;
  end
  // speed register
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      motor_speed <= 16'h0000;
    else
      motor_speed <= speed_nxt;
  end
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
/*
  Bench of the stop sequencer: Wishbone tasks, pin stimulus, motor model.
  Assumes short counts set by parameter.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  import stop_seq_pkg::*;
  logic        sys_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        servo_enable_input, fault_clear_input, alarm_input;
  logic        main_power_input, servo_on_status, cmd_accept_output;
  logic        drive_ready_output, fault_output, motor_power_output;
  logic        reverse_torque_output, dyn_brake_output, holding_brake_output;
  logic        brake_release_output_valid, brake_engage_output;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [15:0] motor_speed, torque_limit_output;
  logic [7:0]  ra [6] = '{ADR_DIS_SEL, ADR_FLT_SEL, ADR_TORQUE, ADR_MAX_TIME,
                          ADR_THRESHOLD, 8'h20};
  logic [15:0] rv [6] = '{DIS_SEL_RST, FLT_SEL_RST, TORQUE_RST, MAX_TIME_RST,
                          THRESHOLD_RST, 16'h0000};
  logic [15:0] mt [3] = '{16'h03e8, 16'h0002, 16'h03e8};
  int          lim [3] = '{200, 20, 200};
  int          error_cnt = 0, comparisons = 0, n;
  wire  [3:0]  ev = {brake_engage_output, cmd_accept_output, servo_on_status,
                     drive_ready_output};
  // design and far side
  servo_stop_sequencer #(.INIT_CNT(8), .SETTLE_CNT(16), .TICK_CNT(4)) u_dut
  (.sys_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
   .wb_dat_i, .wb_dat_o, .wb_ack_o, .servo_enable_input, .fault_clear_input,
   .alarm_input, .main_power_input, .motor_speed, .servo_on_status,
   .cmd_accept_output, .drive_ready_output, .fault_output, .motor_power_output,
   .reverse_torque_output, .torque_limit_output, .dyn_brake_output,
   .holding_brake_output, .brake_release_output_valid, .brake_engage_output);
  motor_model u_motor
  (.sys_clk, .nrst, .motor_power_output, .reverse_torque_output,
   .dyn_brake_output, .motor_speed);
  // ********
  // tasks
  // ********
  task automatic finish_test();
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tmo();
    error_cnt++;
    finish_test();
  endtask
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task automatic wb(logic [7:0] a, logic w, logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (k >= 50)
      tmo();
  endtask
  // bounded wait for one event bit
  task automatic wt(int b, int l);
    n = 0;
    while (ev[b] !== 1'b1 && n < l)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= l)
      tmo();
  endtask
  // ********
  // clock and sequence
  // ********
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial
  begin
    {wb_cyc_i, wb_stb_i, wb_we_i, fault_clear_input, alarm_input} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i, servo_enable_input} = '0;
    main_power_input = 1'b0;
    nrst = 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      wb(ra[i], 1'b0, 32'h0000_0000);
      cmp("register read", 32'(rv[i]), q);
    end
    cmp("ready without power", 0, drive_ready_output);
    main_power_input <= 1'b1;
    wt(0, 100);
    cmp("idle dyn brake", 1, dyn_brake_output);
    wb(ADR_STATUS, 1'b0, 32'h0000_0000);
    cmp("status", 32'h0000_0491, q);
    for (int m = 0; m < 3; m++)
    begin
      wb(ADR_DIS_SEL, 1'b1, 32'(m * 17));
      wb(ADR_MAX_TIME, 1'b1, 32'(mt[m]));
      servo_enable_input <= 1'b1;
      wt(1, 20);
      cmp("run power", 1, motor_power_output);
      cmp("run release", 1, brake_release_output_valid);
      wt(2, 40);
      repeat (20) @(posedge sys_clk);
      servo_enable_input <= 1'b0;
      repeat (4) @(posedge sys_clk);
      cmp("servo off", 0, servo_on_status);
      cmp("reverse", m == 0, reverse_torque_output);
      cmp("decel power", m == 0, motor_power_output);
      cmp("decel dyn", m == 2, dyn_brake_output);
      cmp("torque", m == 0 ? 32'(TORQUE_RST) : 32'h0000_0000, torque_limit_output);
      wt(3, lim[m]);
      cmp("after dyn", m == 1, dyn_brake_output);
      cmp("after power", 0, motor_power_output);
      cmp("after brake", 0, holding_brake_output);
    end
    wb(ADR_FLT_SEL, 1'b1, 32'h0000_0010);
    servo_enable_input <= 1'b1;
    wt(2, 40);
    repeat (20) @(posedge sys_clk);
    alarm_input <= 1'b1;
    repeat (4) @(posedge sys_clk);
    cmp("fault", 1, fault_output);
    cmp("alarm reverse", 1, reverse_torque_output);
    wt(3, 200);
    cmp("alarm dyn", 1, dyn_brake_output);
    cmp("alarm ready", 0, drive_ready_output);
    alarm_input <= 1'b0;
    servo_enable_input <= 1'b0;
    repeat (4) @(posedge sys_clk);
    fault_clear_input <= 1'b1;
    wt(0, 20);
    cmp("cleared", 0, fault_output);
    finish_test();
  end
endmodule
bind servo_stop_sequencer stop_seq_checker u_chk
(.sys_clk, .nrst, .main_power_input, .servo_on_status, .cmd_accept_output,
 .drive_ready_output, .fault_output, .motor_power_output, .reverse_torque_output,
 .torque_limit_output, .dyn_brake_output, .holding_brake_output,
 .brake_release_output_valid, .brake_engage_output);
`default_nettype wire
